// >>> logic/rmcl_map.svh
// Register offsets, field positions, reset values and fixed values for the radio config loader
`ifndef RMCL_MAP_SVH
`define RMCL_MAP_SVH
// Device register offsets
`define RMCL_A_PREAMBLE 10'h102
`define RMCL_A_SYNC_LO 10'h10C
`define RMCL_A_SYNC_MID 10'h10D
`define RMCL_A_SYNC_HI 10'h10E
`define RMCL_A_SYNC_CFG 10'h10F
`define RMCL_A_RADIO_MODE 10'h13E
`define RMCL_A_TX_DEV 10'h304
`define RMCL_A_DISC_BW 10'h305
`define RMCL_A_TX_SHAPE 10'h306
`define RMCL_A_RATE_HI 10'h30E
`define RMCL_A_RATE_LO 10'h30F
`define RMCL_A_PIN_SETUP 10'h32C
`define RMCL_A_PLL_LOCK 10'h335
`define RMCL_A_DIG_IF 10'h389
`define RMCL_A_POSTDEMOD 10'h38B
`define RMCL_A_RX_FRONTEND 10'h39B
`define RMCL_A_GAIN_LOCK 10'h3B2
`define RMCL_A_GAIN_MAX 10'h3B4
`define RMCL_A_GAIN_2 10'h3B6
`define RMCL_A_GAIN_3 10'h3B7
`define RMCL_A_GAIN_4 10'h3B8
`define RMCL_A_GAIN_6 10'h3BA
`define RMCL_A_GAIN_7 10'h3BC
`define RMCL_A_OFS_SETUP0 10'h3BF
`define RMCL_A_OFS_SETUP1 10'h3C4
`define RMCL_A_OFS_BW0 10'h3D2
`define RMCL_A_OFS_BW1 10'h3D3
`define RMCL_A_OFS_BW2 10'h3D4
`define RMCL_A_OFS_BW3 10'h3D5
`define RMCL_A_OFS_BW4 10'h3D6
`define RMCL_A_OFS_BWSEL 10'h3D7
`define RMCL_A_OFS_BW13 10'h3E0
`define RMCL_A_PRE_CHECK 10'h3F3
`define RMCL_A_SFD 10'h3F4
`define RMCL_A_FT_SETUP 10'h3F7
`define RMCL_A_FT_GAINS 10'h3F8
`define RMCL_A_FT_RANGE 10'h3F9
// Fixed values
`define RMCL_V_MODE_FSK_PKT 8'h04
`define RMCL_V_MODE_FSK_SERIAL_PORT_MODE 8'h03
`define RMCL_V_SHAPE_IEEE 8'h01
`define RMCL_V_FT_SETUP 8'h07
`define RMCL_V_FT_GAINS 8'h99
`define RMCL_V_FT_RANGE 8'h50
`define RMCL_V_PREAMBLE_PAT 24'hAAAAAA
`define RMCL_V_LNA_PORT1 3'h0
`define RMCL_V_LNA_PORT2 3'h1
`define RMCL_LAST_COMMON 6'd17
`define RMCL_LAST_STEP 6'd36
// Software register word offsets
`define RMCL_R_CTRL 4'h0
`define RMCL_R_SERIAL_PORT_MODE 4'h1
`define RMCL_R_SYNC 4'h2
`define RMCL_R_MISC 4'h3
`define RMCL_R_STATUS 4'h4
// Software register fields and reset values
`define RMCL_F_START 8
`define RMCL_F_LOST 2
`define RMCL_RST_CTRL 32'h0000_0000
`define RMCL_RST_SERIAL_PORT_MODE 32'h0000_0000
`define RMCL_RST_SYNC 32'h10AA_7F31
`define RMCL_RST_MISC 32'h0000_0600
`endif

// >>> logic/rmcl_pkg.sv
// Types shared by the radio config loader modules
package rmcl_pkg;
  typedef enum logic [1:0] {
    RMCL_FSK_PKT = 2'b00,
    RMCL_FSK_SERIAL_PORT_MODE = 2'b01,
    RMCL_IEEE_PKT = 2'b10,
    RMCL_IEEE_SERIAL_PORT_MODE = 2'b11
  } rmcl_mode_t;

  typedef enum logic [1:0] {
    RMCL_ST_IDLE = 2'b00,
    RMCL_ST_RESET = 2'b01,
    RMCL_ST_WRITE = 2'b10
  } rmcl_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } rmcl_wr_t;

  typedef struct packed {
    logic [7:0] preamble;
    logic [7:0] tx_dev;
    logic [7:0] disc_bw;
    logic [7:0] tx_shape;
    logic [7:0] rate_hi;
    logic [7:0] rate_lo;
    logic [7:0] dig_if;
    logic [7:0] postdemod;
    logic [3:0] bb_bw;
  } rmcl_rate_t;
endpackage

// >>> logic/rmcl_rate_table.sv
// Data-rate dependent FSK settings lookup
`timescale 1ns/1ps
`default_nettype none
module rmcl_rate_table
  import rmcl_pkg::*;
(
  input wire logic [2:0] rate_sel,
  output rmcl_rate_t rate
);
  // Order: preamble, deviation, disc bw, shaping, rate hi, rate lo, if filter, postdemod, bb bw
  always_comb begin
    unique case (rate_sel)
      3'h0: rate = '{8'h04, 8'h03, 8'h37, 8'h00, 8'h01, 8'hF4, 8'h17, 8'h08, 4'h6};
      3'h1: rate = '{8'h04, 8'h06, 8'h37, 8'h00, 8'h02, 8'h71, 8'h17, 8'h08, 4'h6};
      3'h2: rate = '{8'h05, 8'h03, 8'h6B, 8'h00, 8'h03, 8'hE8, 8'h17, 8'h0D, 4'h6};
      3'h3: rate = '{8'h05, 8'h06, 8'h37, 8'h00, 8'h04, 8'hE2, 8'h17, 8'h11, 4'h6};
      3'h4: rate = '{8'h05, 8'h0D, 8'h19, 8'h02, 8'h09, 8'hC4, 8'h12, 8'h20, 4'h6};
      3'h5: rate = '{8'h05, 8'h19, 8'h0D, 8'h03, 8'h13, 8'h88, 8'h0A, 8'h3D, 4'h6};
      3'h6: rate = '{8'h07, 8'h19, 8'h0D, 8'h03, 8'h27, 8'h10, 8'h05, 8'h6E, 4'h6};
      3'h7: rate = '{8'h09, 8'h32, 8'h06, 8'h03, 8'h4E, 8'h20, 8'h05, 8'hAA, 4'hD};
    endcase
  end
endmodule
`default_nettype wire

// >>> logic/rmcl_loader.sv
// Host-side loader that writes one of four radio configurations into the transceiver
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rmcl_map.svh"
module rmcl_loader
  import rmcl_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] sw_addr,
  input wire logic [DATA_W-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [DATA_W-1:0] sw_rdata,
  output logic dev_wr_valid,
  output rmcl_wr_t dev_wr,
  input wire logic dev_wr_ready,
  output logic radio_controller_reset_cmd,
  input wire logic dev_cmd_ready,
  output logic cfg_ready,
  output logic busy
);
  rmcl_state_t state_ff;
  logic [5:0] step_ff;
  logic wr_valid_ff;
  rmcl_wr_t wr_ff;
  logic cmd_ff;
  logic busy_ff;
  logic cfg_ready_ff;
  logic cfg_valid_ff;
  logic family_ff;
  logic lost_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] serial_port_mode_ff;
  logic [DATA_W-1:0] sync_ff;
  logic [DATA_W-1:0] misc_ff;

  rmcl_mode_t mode;
  logic fsk;
  logic serial_port_mode;
  logic afc_en;
  logic rx_port1;
  logic sfd_en;
  logic [4:0] sync_len;
  logic [1:0] sync_tol;
  logic [23:0] sync_pad;
  logic [23:0] sync_keep;
  rmcl_rate_t rate;
  rmcl_wr_t step_wr;
  logic step_skip;
  logic sw_hit_ctrl;
  logic start_req;
  logic start_go;
  logic need_rst;
  logic wr_accept;
  logic lost_set;
  logic lost_clr;

  assign mode = rmcl_mode_t'(ctrl_ff[1:0]);
  assign fsk = ~ctrl_ff[1];
  assign serial_port_mode = ctrl_ff[0];
  assign afc_en = ctrl_ff[5];
  assign rx_port1 = ctrl_ff[6];
  assign sfd_en = ctrl_ff[7];
  assign sync_len = sync_ff[28:24];
  assign sync_tol = sync_ff[30:29];

  assign sw_hit_ctrl = sw_wr && (sw_addr == `RMCL_R_CTRL);
  assign start_req = ce && sw_hit_ctrl && sw_wdata[`RMCL_F_START];
  assign start_go = start_req && (state_ff == RMCL_ST_IDLE);
  assign need_rst = !cfg_valid_ff || (family_ff != sw_wdata[1]);
  assign wr_accept = wr_valid_ff && dev_wr_ready;

  rmcl_rate_table u_rate (
    .rate_sel(ctrl_ff[4:2]),
    .rate(rate)
  );

  always_comb begin
    sync_keep = '0;
    for (int k = 0; k < 24; k++) begin
      sync_keep[k] = (5'(k) < sync_len);
    end
    sync_pad = (sync_ff[23:0] & sync_keep) | (`RMCL_V_PREAMBLE_PAT & ~sync_keep);
  end

  // Write list decode, one entry per step
  always_comb begin
    step_wr = '0;
    step_skip = 1'b1;
    case (step_ff)
      6'd0: step_wr = '{`RMCL_A_PLL_LOCK, 8'h28};
      6'd1: step_wr = '{`RMCL_A_GAIN_LOCK, 8'h34};
      6'd2: step_wr = '{`RMCL_A_GAIN_MAX, 8'h80};
      6'd3: step_wr = '{`RMCL_A_GAIN_2, 8'h37};
      6'd4: step_wr = '{`RMCL_A_GAIN_3, 8'h2A};
      6'd5: step_wr = '{`RMCL_A_GAIN_4, 8'h1D};
      6'd6: step_wr = '{`RMCL_A_GAIN_6, 8'h24};
      6'd7: step_wr = '{`RMCL_A_GAIN_7, 8'h7B};
      6'd8: step_wr = '{`RMCL_A_OFS_SETUP0, 8'h00};
      6'd9: step_wr = '{`RMCL_A_OFS_SETUP1, 8'h07};
      6'd10: step_wr = '{`RMCL_A_OFS_BW0, 8'h1A};
      6'd11: step_wr = '{`RMCL_A_OFS_BW1, 8'h19};
      6'd12: step_wr = '{`RMCL_A_OFS_BW2, 8'h1E};
      6'd13: step_wr = '{`RMCL_A_OFS_BW3, 8'h1E};
      6'd14: step_wr = '{`RMCL_A_OFS_BW4, 8'h1E};
      6'd15: step_wr = '{`RMCL_A_OFS_BWSEL, 8'h00};
      6'd16: step_wr = '{`RMCL_A_OFS_BW13, 8'hF0};
      6'd17: step_wr = '{`RMCL_A_PRE_CHECK, 8'h01};
      6'd18: begin
        step_wr = '{`RMCL_A_PREAMBLE, rate.preamble};
        step_skip = (mode != RMCL_FSK_PKT);
      end
      6'd19: begin
        step_wr = '{`RMCL_A_TX_DEV, rate.tx_dev};
        step_skip = !fsk;
      end
      6'd20: begin
        step_wr = '{`RMCL_A_DISC_BW, rate.disc_bw};
        step_skip = !fsk;
      end
      6'd21: begin
        step_wr = '{`RMCL_A_TX_SHAPE, fsk ? rate.tx_shape : `RMCL_V_SHAPE_IEEE};
        step_skip = (mode == RMCL_IEEE_PKT);
      end
      6'd22: begin
        step_wr = '{`RMCL_A_RATE_HI, rate.rate_hi};
        step_skip = !fsk;
      end
      6'd23: begin
        step_wr = '{`RMCL_A_RATE_LO, rate.rate_lo};
        step_skip = !fsk;
      end
      6'd24: begin
        step_wr = '{`RMCL_A_DIG_IF, rate.dig_if};
        step_skip = !fsk;
      end
      6'd25: begin
        step_wr = '{`RMCL_A_POSTDEMOD, rate.postdemod};
        step_skip = !fsk;
      end
      6'd26: begin
        step_wr.addr = `RMCL_A_RX_FRONTEND;
        step_wr.data = {1'b0, rx_port1 ? `RMCL_V_LNA_PORT1 : `RMCL_V_LNA_PORT2,
                        fsk ? rate.bb_bw : misc_ff[11:8]};
        step_skip = (mode == RMCL_IEEE_PKT) && !rx_port1;
      end
      6'd27: begin
        step_wr.addr = `RMCL_A_RADIO_MODE;
        step_wr.data = !fsk ? serial_port_mode_ff[23:16] :
                       (serial_port_mode ? `RMCL_V_MODE_FSK_SERIAL_PORT_MODE : `RMCL_V_MODE_FSK_PKT);
        step_skip = (mode == RMCL_IEEE_PKT);
      end
      6'd28: begin
        step_wr = '{`RMCL_A_PIN_SETUP, fsk ? serial_port_mode_ff[7:0] : serial_port_mode_ff[15:8]};
        step_skip = !serial_port_mode;
      end
      6'd29: begin
        step_wr = '{`RMCL_A_SYNC_LO, sync_pad[7:0]};
        step_skip = !fsk;
      end
      6'd30: begin
        step_wr = '{`RMCL_A_SYNC_MID, sync_pad[15:8]};
        step_skip = !fsk;
      end
      6'd31: begin
        step_wr = '{`RMCL_A_SYNC_HI, sync_pad[23:16]};
        step_skip = !fsk;
      end
      6'd32: begin
        step_wr = '{`RMCL_A_SYNC_CFG, {1'b0, sync_tol, sync_len}};
        step_skip = !fsk;
      end
      6'd33: begin
        step_wr = '{`RMCL_A_SFD, misc_ff[7:0]};
        step_skip = fsk || !sfd_en;
      end
      6'd34: begin
        step_wr = '{`RMCL_A_FT_SETUP, `RMCL_V_FT_SETUP};
        step_skip = !(fsk && afc_en);
      end
      6'd35: begin
        step_wr = '{`RMCL_A_FT_GAINS, `RMCL_V_FT_GAINS};
        step_skip = !(fsk && afc_en);
      end
      6'd36: begin
        step_wr = '{`RMCL_A_FT_RANGE, `RMCL_V_FT_RANGE};
        step_skip = !(fsk && afc_en);
      end
      default: step_wr = '0;
    endcase
    if (step_ff <= `RMCL_LAST_COMMON) begin
      step_skip = !fsk;
    end
  end

  // Sequencer and device-side outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= RMCL_ST_IDLE;
      step_ff <= '0;
      wr_valid_ff <= 1'b0;
      wr_ff <= '0;
      cmd_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      unique case (state_ff)
        RMCL_ST_IDLE: begin
          if (start_go) begin
            step_ff <= '0;
            cmd_ff <= need_rst;
            busy_ff <= 1'b1;
            state_ff <= need_rst ? RMCL_ST_RESET : RMCL_ST_WRITE;
          end
        end
        RMCL_ST_RESET: begin
          if (dev_cmd_ready) begin
            cmd_ff <= 1'b0;
            state_ff <= RMCL_ST_WRITE;
          end
        end
        RMCL_ST_WRITE: begin
          if (wr_valid_ff) begin
            if (dev_wr_ready) begin
              wr_valid_ff <= 1'b0;
              step_ff <= step_ff + 6'd1;
            end
          end else if (step_ff > `RMCL_LAST_STEP) begin
            state_ff <= RMCL_ST_IDLE;
            busy_ff <= 1'b0;
          end else if (step_skip) begin
            step_ff <= step_ff + 6'd1;
          end else begin
            wr_valid_ff <= 1'b1;
            wr_ff <= step_wr;
          end
        end
        default: state_ff <= RMCL_ST_IDLE;
      endcase
    end
  end

  // ready only after the last write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_ready_ff <= 1'b0;
      cfg_valid_ff <= 1'b0;
      family_ff <= 1'b0;
    end else if (ce) begin
      if (start_go) begin
        cfg_ready_ff <= 1'b0;
        cfg_valid_ff <= 1'b0;
      end else if (state_ff == RMCL_ST_WRITE && !wr_valid_ff && step_ff > `RMCL_LAST_STEP) begin
        cfg_ready_ff <= 1'b1;
        cfg_valid_ff <= 1'b1;
        family_ff <= ctrl_ff[1];
      end
    end
  end

  // Software registers, locked while a load runs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_ff <= `RMCL_RST_CTRL;
      serial_port_mode_ff <= `RMCL_RST_SERIAL_PORT_MODE;
      sync_ff <= `RMCL_RST_SYNC;
      misc_ff <= `RMCL_RST_MISC;
    end else if (ce && sw_wr && state_ff == RMCL_ST_IDLE) begin
      case (sw_addr)
        `RMCL_R_CTRL: ctrl_ff <= {24'h000000, sw_wdata[7:0]};
        `RMCL_R_SERIAL_PORT_MODE: serial_port_mode_ff <= {8'h00, sw_wdata[23:0]};
        `RMCL_R_SYNC: sync_ff <= {1'b0, sw_wdata[30:0]};
        `RMCL_R_MISC: misc_ff <= {20'h00000, sw_wdata[11:0]};
        default: ;
      endcase
    end
  end

  // Start while busy is dropped and flagged; set wins over clear
  assign lost_set = start_req && (state_ff != RMCL_ST_IDLE);
  assign lost_clr = sw_wr && (sw_addr == `RMCL_R_STATUS) && sw_wdata[`RMCL_F_LOST];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lost_ff <= 1'b0;
    end else if (ce) begin
      if (lost_set) begin
        lost_ff <= 1'b1;
      end else if (lost_clr) begin
        lost_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= '0;
      if (sw_rd) begin
        case (sw_addr)
          `RMCL_R_CTRL: rdata_ff <= ctrl_ff;
          `RMCL_R_SERIAL_PORT_MODE: rdata_ff <= serial_port_mode_ff;
          `RMCL_R_SYNC: rdata_ff <= sync_ff;
          `RMCL_R_MISC: rdata_ff <= misc_ff;
          `RMCL_R_STATUS: rdata_ff <= {18'h00000, step_ff, 3'h0, family_ff, cfg_valid_ff,
                                       lost_ff, cfg_ready_ff, state_ff != RMCL_ST_IDLE};
          default: rdata_ff <= '0;
        endcase
      end
    end
  end

  assign sw_rdata = rdata_ff;
  assign dev_wr_valid = wr_valid_ff;
  assign dev_wr = wr_ff;
  assign radio_controller_reset_cmd = cmd_ff;
  assign cfg_ready = cfg_ready_ff;
  assign busy = busy_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  common_lock_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_PLL_LOCK
    |-> dev_wr.data == 8'h28 && fsk) else $error("lock time value wrong");
  rate_pair_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_RATE_LO
    && ctrl_ff[4:2] == 3'h0 |-> dev_wr.data == 8'hF4) else $error("rate low byte wrong");
  preamble_pkt_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_PREAMBLE
    |-> mode == RMCL_FSK_PKT) else $error("preamble written outside FSK packet");
  mode_value_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_RADIO_MODE && fsk
    |-> dev_wr.data == (serial_port_mode ? 8'h03 : 8'h04)) else $error("radio mode value wrong");
  sync_pad_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_SYNC_HI
    && sync_len <= 5'd16 |-> dev_wr.data == 8'hAA) else $error("sync high byte not padded");
  sync_len_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_SYNC_CFG
    |-> dev_wr.data[4:0] == sync_len && dev_wr.data[6:5] == sync_tol)
    else $error("sync setup mismatch");
  afc_setup_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_FT_SETUP
    |-> afc_en && fsk && dev_wr.data == 8'h07) else $error("tracking setup wrong");
  afc_range_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_FT_RANGE
    |-> dev_wr.data == 8'h50) else $error("tracking range wrong");
  ieee_pkt_a: assert property (dev_wr_valid && mode == RMCL_IEEE_PKT
    |-> (dev_wr.addr == `RMCL_A_RX_FRONTEND && rx_port1) || dev_wr.addr == `RMCL_A_SFD)
    else $error("unneeded write in IEEE packet mode");
  ieee_shape_a: assert property (dev_wr_valid && mode == RMCL_IEEE_SERIAL_PORT_MODE
    && dev_wr.addr == `RMCL_A_TX_SHAPE |-> dev_wr.data == 8'h01) else $error("shaping wrong");
  sfd_extra_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_SFD
    |-> sfd_en && !fsk) else $error("delimiter write not requested");
  lna_select_a: assert property (dev_wr_valid && dev_wr.addr == `RMCL_A_RX_FRONTEND
    |-> dev_wr.data[6:4] == (rx_port1 ? 3'h0 : 3'h1)) else $error("port select wrong");
  switch_reset_a: assert property (start_go && need_rst
    |=> radio_controller_reset_cmd && !dev_wr_valid) else $error("missing controller reset");
  ready_after_a: assert property (dev_wr_valid || radio_controller_reset_cmd
    |-> !cfg_ready) else $error("ready raised during load");
  hold_write_a: assert property (dev_wr_valid && !dev_wr_ready
    |=> dev_wr_valid && $stable(dev_wr)) else $error("write dropped before accept");

  fsk_pkt_c: cover property (dev_wr_valid && dev_wr_ready && mode == RMCL_FSK_PKT
    && dev_wr.addr == `RMCL_A_FT_RANGE);
  ieee_serial_port_mode_c: cover property (dev_wr_valid && dev_wr_ready && mode == RMCL_IEEE_SERIAL_PORT_MODE);
  family_rst_c: cover property (radio_controller_reset_cmd && dev_cmd_ready
    && cfg_valid_ff == 1'b0);
  lost_c: cover property (lost_set);
endmodule
`default_nettype wire

// >>> testbench/rmcl_dev_model.sv
// Behavioural transceiver register file on the far side of the loader
`timescale 1ns/1ps
`default_nettype none
module rmcl_dev_model
  import rmcl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic slow,
  input wire logic dev_wr_valid,
  input wire rmcl_wr_t dev_wr,
  output logic dev_wr_ready,
  input wire logic radio_controller_reset_cmd,
  output logic dev_cmd_ready
);
  logic [7:0] mem [0:1023];
  logic [1:0] pace_ff;
  logic rf_port1_active;
  logic rf_port2_active;
  int n_wr = 0;
  int n_cmd = 0;
  int wr_at_cmd = 0;
  // one receive port live, never both
  assign rf_port1_active = (mem[10'h39B][6:4] == 3'h0);
  assign rf_port2_active = !rf_port1_active;
  // Slow mode accepts one request in three cycles
  assign dev_wr_ready = !slow || (pace_ff == 2'h2);
  assign dev_cmd_ready = !slow || (pace_ff == 2'h1);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pace_ff <= 2'h0;
    end else begin
      pace_ff <= (pace_ff == 2'h2) ? 2'h0 : pace_ff + 2'h1;
    end
  end
  always @(posedge clk_sys) begin
    if (dev_wr_valid && dev_wr_ready) begin
      mem[dev_wr.addr] <= dev_wr.data;
      n_wr <= n_wr + 1;
    end
    if (radio_controller_reset_cmd && dev_cmd_ready) begin
      n_cmd <= n_cmd + 1;
      wr_at_cmd <= n_wr;
    end
  end
  // defaults work alone, receive on port 2
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'h00;
    end
    mem[10'h39B] = 8'h16;
  end
endmodule
`default_nettype wire

// >>> testbench/test_rmcl_loader.sv
// Self-checking bench for the radio configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "rmcl_map.svh"
module test_rmcl_loader
  import rmcl_pkg::*;
();
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic slow = 1'b0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic [31:0] sw_rdata;
  logic dev_wr_valid;
  logic dev_wr_ready;
  logic rc_cmd;
  logic dev_cmd_ready;
  logic cfg_ready;
  logic busy;
  rmcl_wr_t dev_wr;
  int n_mismatch = 0;
  int tests_run = 0;
  rmcl_loader rmcl_loader_i (.clk_sys(clk_sys), .reset(reset), .ce(ce), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_wr_valid(dev_wr_valid), .dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready),
    .radio_controller_reset_cmd(rc_cmd), .dev_cmd_ready(dev_cmd_ready),
    .cfg_ready(cfg_ready), .busy(busy));
  rmcl_dev_model rmcl_dev_model_i (.clk_sys(clk_sys), .reset(reset), .slow(slow),
    .dev_wr_valid(dev_wr_valid), .dev_wr(dev_wr), .dev_wr_ready(dev_wr_ready),
    .radio_controller_reset_cmd(rc_cmd), .dev_cmd_ready(dev_cmd_ready));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_dev(input logic [9:0] a, input logic [7:0] exp);
    chk($sformatf("device byte %h", a), {24'h0, exp}, {24'h0, rmcl_dev_model_i.mem[a]});
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 3000) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if (i >= 3000) begin
      n_mismatch++;
      $display("BAD busy timeout expected 0 seen 1");
      report_and_stop();
    end
    chk("cfg_ready", 32'h1, {31'h0, cfg_ready});
  endtask
  task automatic run_load(input logic [31:0] ctrl, input int exp_wr, input int exp_cmd);
    int base_wr;
    int base_cmd;
    int base_at;
    base_wr = rmcl_dev_model_i.n_wr;
    base_cmd = rmcl_dev_model_i.n_cmd;
    base_at = rmcl_dev_model_i.wr_at_cmd;
    sw_write(`RMCL_R_CTRL, ctrl);
    #1;
    chk("busy", 32'h1, {31'h0, busy});
    // not ready until every write is done
    chk("cfg_ready low", 32'h0, {31'h0, cfg_ready});
    wait_idle();
    chk("write count", exp_wr, rmcl_dev_model_i.n_wr - base_wr);
    chk("reset cmd count", exp_cmd, rmcl_dev_model_i.n_cmd - base_cmd);
    // reset command ahead of any write
    chk("writes before cmd", (exp_cmd != 0) ? base_wr : base_at, rmcl_dev_model_i.wr_at_cmd);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    chk("busy idle", 32'h0, {31'h0, busy});
    sw_read(`RMCL_R_SYNC, d);
    chk("sync reset", 32'h10AA_7F31, d);
    sw_read(`RMCL_R_MISC, d);
    chk("misc reset", 32'h0000_0600, d);
    // Clock enable low freezes the register file
    @(posedge clk_sys);
    ce <= 1'b0;
    sw_write(`RMCL_R_MISC, 32'h0000_0123);
    ce <= 1'b1;
    sw_read(`RMCL_R_MISC, d);
    chk("misc frozen", 32'h0000_0600, d);
    sw_read(`RMCL_R_STATUS, d);
    chk("status reset", 32'h0, d);
    sw_read(4'hF, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
  endtask
  task automatic t_fsk_pkt();
    slow = 1'b1;
    run_load(32'h120, 35, 1);
    chk_dev(10'h335, 8'h28);
    chk_dev(10'h3B4, 8'h80);
    chk_dev(10'h3F3, 8'h01);
    chk_dev(10'h30E, 8'h01);
    chk_dev(10'h30F, 8'hF4);
    chk_dev(10'h102, 8'h04);
    chk_dev(10'h13E, 8'h04);
    chk_dev(10'h10C, 8'h31);
    chk_dev(10'h10D, 8'h7F);
    chk_dev(10'h10E, 8'hAA);
    chk_dev(10'h10F, 8'h10);
    chk_dev(10'h3F7, 8'h07);
    chk_dev(10'h3F8, 8'h99);
    chk_dev(10'h3F9, 8'h50);
    chk_dev(10'h39B, 8'h16);
    $display("test fsk packet done");
  endtask
  task automatic t_fsk_serial_port_mode();
    slow = 1'b0;
    sw_write(`RMCL_R_SERIAL_PORT_MODE, 32'h0000_0001);
    sw_write(`RMCL_R_SYNC, 32'h0812_3456);
    run_load(32'h11D, 32, 0);
    chk_dev(10'h13E, 8'h03);
    chk_dev(10'h32C, 8'h01);
    chk_dev(10'h30E, 8'h4E);
    chk_dev(10'h30F, 8'h20);
    chk_dev(10'h39B, 8'h1D);
    chk_dev(10'h10C, 8'h56);
    chk_dev(10'h10D, 8'hAA);
    chk_dev(10'h10E, 8'hAA);
    chk_dev(10'h10F, 8'h08);
    $display("test fsk serial done");
  endtask
  task automatic t_ieee();
    run_load(32'h102, 0, 1);
    run_load(32'h142, 1, 0);
    chk_dev(10'h39B, 8'h06);
    chk("rf port 1 live", 32'h1, {31'h0, rmcl_dev_model_i.rf_port1_active});
    sw_write(`RMCL_R_SERIAL_PORT_MODE, 32'h0002_0700);
    sw_write(`RMCL_R_MISC, 32'h0000_06A7);
    run_load(32'h183, 5, 0);
    chk_dev(10'h306, 8'h01);
    chk_dev(10'h13E, 8'h02);
    chk_dev(10'h32C, 8'h07);
    chk_dev(10'h3F4, 8'hA7);
    chk_dev(10'h39B, 8'h16);
    chk("rf port 2 live", 32'h1, {31'h0, rmcl_dev_model_i.rf_port2_active});
    $display("test ieee done");
  endtask
  task automatic t_lost();
    logic [31:0] d;
    slow = 1'b1;
    sw_write(`RMCL_R_CTRL, 32'h100);
    sw_write(`RMCL_R_CTRL, 32'h101);
    sw_write(`RMCL_R_SYNC, 32'h0);
    wait_idle();
    chk_dev(10'h13E, 8'h04);
    sw_read(`RMCL_R_SYNC, d);
    chk("sync kept", 32'h0812_3456, d);
    sw_read(`RMCL_R_STATUS, d);
    chk("status lost", 32'h0E, d & 32'h1F);
    sw_write(`RMCL_R_STATUS, 32'h4);
    sw_read(`RMCL_R_STATUS, d);
    chk("status cleared", 32'h0A, d & 32'h1F);
    $display("test start lost done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_fsk_pkt();
    t_fsk_serial_port_mode();
    t_ieee();
    t_lost();
    report_and_stop();
  end
endmodule
`default_nettype wire
